//--- logic/sixteen_bit_gated_timer.sv
// Functional notes
// - timer, synced counter, unsynced counter modes
// - run bit starts and stops counting
// - idle-halt bit freezes block in idle
// - gating works only with internal clock
// - prescale 1, 8, 64 or 256
// - sync bit matters only for external clock
// - source bit picks pin edges or internal
// - interrupt on match or gate falling edge
// - unimplemented control bits read zero
// - counting may continue in idle or sleep
`timescale 1ns/1ns
`include "timer_defines.svh"
module sixteen_bit_gated_timer
    import timer_pkg::*;
(
    // clock, reset, clock enable
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        ce_i,
    // register port
    input  wire bus_req_t    bus_i,
    output logic [15:0]      rdata_o,
    // external clock and gate pin
    input  wire logic        ext_clock_pin_i,
    // power state from the core
    input  wire logic        cpu_idle_i,
    input  wire logic        cpu_sleep_i,
    // interrupt
    output logic             irq_o,
    output logic [2:0]       irq_priority_o
);
    timer_ctrl_t ctrl;
    timer_ctrl_t next_ctrl;
    logic [15:0] period_value;
    logic [15:0] next_period_value;
    logic [15:0] count;
    logic [15:0] next_count;
    logic [1:0]  irq_status;
    logic [1:0]  next_irq_status;
    logic [1:0]  irq_mask;
    logic [1:0]  next_irq_mask;
    logic        irq_enable_bit;
    logic        next_irq_enable_bit;
    logic [2:0]  irq_priority;
    logic [2:0]  next_irq_priority;
    logic        irq;
    logic        next_irq;
    logic [15:0] rdata;
    logic [15:0] next_rdata;
    logic        sync_rise_d;
    logic        next_sync_rise_d;

    count_mode_t mode;
    logic        pin_level;
    logic        pin_rise;
    logic        pin_fall;
    logic        halted;
    logic        active;
    logic        src_tick;
    logic        ps_clear;
    logic        cnt_tick;
    logic        match_evt;
    logic        gate_fall_evt;
    logic        wr_ctrl;
    logic        wr_count;
    logic [1:0]  events;

    // control word with unimplemented positions forced low
    function automatic logic [15:0] ctrl_word(input timer_ctrl_t c);
        logic [15:0] w;
        w = 16'h0000;
        w[`CTRL_RUN_BIT]              = c.count_run;
        w[`CTRL_IDLE_BIT]             = c.idle_halt;
        w[`CTRL_GATE_BIT]             = c.gated_accumulate;
        w[`CTRL_PS_HI:`CTRL_PS_LO]    = c.prescale_select;
        w[`CTRL_SYNC_BIT]             = c.ext_clock_sync;
        w[`CTRL_SRC_BIT]              = c.clock_source_select;
        ctrl_word = w & `CTRL_IMPL_MASK;
    endfunction

    // counting source from source, gate and sync bits
    function automatic count_mode_t decode_mode(input timer_ctrl_t c);
        if (c.clock_source_select)
            decode_mode = c.ext_clock_sync ? MODE_SYNC_COUNT : MODE_ASYNC_COUNT;
        else
            decode_mode = c.gated_accumulate ? MODE_GATED : MODE_TIMER;
    endfunction

    // prescaler terminal count, mirrored for checking
    function automatic logic [7:0] ps_last(input logic [1:0] sel);
        case (sel)
            2'h3:    ps_last = `PS_LAST_DIV256;
            2'h2:    ps_last = `PS_LAST_DIV64;
            2'h1:    ps_last = `PS_LAST_DIV8;
            default: ps_last = `PS_LAST_DIV1;
        endcase
    endfunction

    pin_sync u_pin_sync
    (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .ce_i    (ce_i),
        .pin_i   (ext_clock_pin_i),
        .level_o (pin_level),
        .rise_o  (pin_rise),
        .fall_o  (pin_fall)
    );

    // mode and power gating; sleep stops the instruction clock, so only the
    // unsynced counter keeps going there
    always_comb
    begin
        mode   = decode_mode(ctrl);
        halted = (cpu_idle_i & ctrl.idle_halt)
               | (cpu_sleep_i & (ctrl.idle_halt | (mode != MODE_ASYNC_COUNT)));
        active = ctrl.count_run & ~halted;
        case (mode)
            MODE_TIMER:       src_tick = active;
            MODE_GATED:       src_tick = active & pin_level;
            MODE_SYNC_COUNT:  src_tick = active & sync_rise_d;
            MODE_ASYNC_COUNT: src_tick = active & pin_rise;
            default:          src_tick = 1'b0;
        endcase
    end

    // synced counting retimes the edge once more onto the instruction clock
    assign next_sync_rise_d = pin_rise;

    assign wr_ctrl  = bus_i.we & (bus_i.addr == `ADDR_CONTROL);
    assign wr_count = bus_i.we & (bus_i.addr == `ADDR_COUNT);
    // a stop or a control or count write restarts the prescaler phase
    assign ps_clear = ~ctrl.count_run | wr_ctrl | wr_count;

    prescaler u_prescaler
    (
        .clk_i    (clk_i),
        .rst_n_i  (rst_n_i),
        .ce_i     (ce_i),
        .clear_i  (ps_clear),
        .select_i (ctrl.prescale_select),
        .tick_i   (src_tick),
        .tick_o   (cnt_tick)
    );

    // counter and events
    always_comb
    begin
        match_evt     = cnt_tick & (count == period_value);
        gate_fall_evt = active & (mode == MODE_GATED) & pin_fall;
        events        = 2'h0;
        events[`IRQ_MATCH_BIT] = match_evt;
        events[`IRQ_GATE_BIT]  = gate_fall_evt;
        next_count = count;
        if (wr_count)
            next_count = bus_i.wdata;
        else if (match_evt)
            next_count = 16'h0000;
        else if (cnt_tick)
            next_count = 16'(count + 16'h0001);
    end

    // register writes; status clears by writing ones, a new event wins
    always_comb
    begin
        next_ctrl           = ctrl;
        next_period_value   = period_value;
        next_irq_mask       = irq_mask;
        next_irq_enable_bit = irq_enable_bit;
        next_irq_priority   = irq_priority;
        next_irq_status     = irq_status;
        if (bus_i.we)
        begin
            case (bus_i.addr)
                `ADDR_CONTROL:
                begin
                    next_ctrl.count_run           = bus_i.wdata[`CTRL_RUN_BIT];
                    next_ctrl.idle_halt           = bus_i.wdata[`CTRL_IDLE_BIT];
                    next_ctrl.gated_accumulate    = bus_i.wdata[`CTRL_GATE_BIT];
                    next_ctrl.prescale_select     = bus_i.wdata[`CTRL_PS_HI:`CTRL_PS_LO];
                    next_ctrl.ext_clock_sync      = bus_i.wdata[`CTRL_SYNC_BIT];
                    next_ctrl.clock_source_select = bus_i.wdata[`CTRL_SRC_BIT];
                end
                `ADDR_PERIOD:     next_period_value = bus_i.wdata;
                `ADDR_IRQ_STATUS: next_irq_status   = irq_status & ~bus_i.wdata[1:0];
                `ADDR_IRQ_MASK:   next_irq_mask     = bus_i.wdata[1:0];
                `ADDR_IRQ_CONFIG:
                begin
                    next_irq_enable_bit = bus_i.wdata[`IRQ_CFG_EN_BIT];
                    next_irq_priority   = bus_i.wdata[`IRQ_CFG_PRIO_HI:`IRQ_CFG_PRIO_LO];
                end
                default: ;
            endcase
        end
        next_irq_status = next_irq_status | events;
        next_irq        = next_irq_enable_bit & |(next_irq_status & next_irq_mask);
    end

    // read data live only in the cycle after the strobe
    always_comb
    begin
        next_rdata = 16'h0000;
        if (bus_i.re)
        begin
            case (bus_i.addr)
                `ADDR_CONTROL:    next_rdata = ctrl_word(ctrl);
                `ADDR_PERIOD:     next_rdata = period_value;
                `ADDR_COUNT:      next_rdata = count;
                `ADDR_IRQ_STATUS: next_rdata = {14'h0000, irq_status};
                `ADDR_IRQ_MASK:   next_rdata = {14'h0000, irq_mask};
                `ADDR_IRQ_CONFIG: next_rdata = {9'h000, irq_priority, 3'h0, irq_enable_bit};
                default:          next_rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ctrl           <= timer_ctrl_t'(7'h00);
            period_value   <= `RST_PERIOD;
            count          <= `RST_COUNT;
            irq_status     <= `RST_IRQ_BITS;
            irq_mask       <= `RST_IRQ_BITS;
            irq_enable_bit <= 1'b0;
            irq_priority   <= `RST_PRIO;
            irq            <= 1'b0;
            rdata          <= 16'h0000;
            sync_rise_d    <= 1'b0;
        end
        else if (ce_i)
        begin
            ctrl           <= next_ctrl;
            period_value   <= next_period_value;
            count          <= next_count;
            irq_status     <= next_irq_status;
            irq_mask       <= next_irq_mask;
            irq_enable_bit <= next_irq_enable_bit;
            irq_priority   <= next_irq_priority;
            irq            <= next_irq;
            rdata          <= next_rdata;
            sync_rise_d    <= next_sync_rise_d;
        end
    end

    assign rdata_o        = rdata;
    assign irq_o          = irq;
    assign irq_priority_o = irq_priority;

    // checking helper: source ticks seen since the last prescaler output
    logic [7:0] since_tick;
    logic [7:0] next_since_tick;
    always_comb
    begin
        next_since_tick = since_tick;
        if (ps_clear | cnt_tick)
            next_since_tick = 8'h00;
        else if (src_tick)
            next_since_tick = 8'(since_tick + 8'h01);
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            since_tick <= 8'h00;
        else if (ce_i)
            since_tick <= next_since_tick;
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    ctrl_read_zero_a: assert property (
        ce_i && bus_i.re && bus_i.addr == `ADDR_CONTROL |=> (rdata_o & ~`CTRL_IMPL_MASK) == 16'h0000)
        else $error("unimplemented control bits read nonzero");
    stopped_holds_a: assert property (
        !ctrl.count_run && !wr_count |=> $stable(count))
        else $error("count moved while stopped");
    idle_freeze_a: assert property (
        cpu_idle_i && ctrl.idle_halt && !wr_count |=> $stable(count))
        else $error("count moved in idle with idle halt");
    gate_ext_ignored_a: assert property (
        ctrl.clock_source_select |-> mode != MODE_GATED && !gate_fall_evt)
        else $error("gating active on external clock");
    prescale_ratio_a: assert property (
        cnt_tick |-> since_tick == ps_last(ctrl.prescale_select))
        else $error("prescaler ratio wrong");
    sync_int_ignored_a: assert property (
        !ctrl.clock_source_select && !ctrl.gated_accumulate && active |-> src_tick)
        else $error("sync bit changed internal mode");
    ext_edge_count_a: assert property (
        ce_i && mode == MODE_ASYNC_COUNT && active && ctrl.prescale_select == 2'h0
        && !wr_ctrl && !wr_count && pin_rise && count != period_value
        |=> count == 16'($past(count) + 16'h0001))
        else $error("external edge not counted");
    match_irq_a: assert property (
        ce_i && match_evt |=> irq_status[`IRQ_MATCH_BIT])
        else $error("match did not set status");
    gate_fall_irq_a: assert property (
        ce_i && gate_fall_evt |=> irq_status[`IRQ_GATE_BIT])
        else $error("gate fall did not set status");
    match_wrap_a: assert property (
        ce_i && match_evt && !wr_count |=> count == 16'h0000)
        else $error("count did not wrap on match");
    sleep_async_runs_a: assert property (
        cpu_sleep_i && !cpu_idle_i && ctrl.count_run && !ctrl.idle_halt
        && mode == MODE_ASYNC_COUNT |-> active)
        else $error("unsynced counter stopped in sleep");

    match_seen_c: cover property (ce_i && match_evt);
    gate_fall_seen_c: cover property (ce_i && gate_fall_evt);
    async_tick_c: cover property (mode == MODE_ASYNC_COUNT && cnt_tick);
    div256_tick_c: cover property (ctrl.prescale_select == 2'h3 && cnt_tick);
endmodule

//--- inc/timer_defines.svh
`ifndef TIMER_DEFINES_SVH
`define TIMER_DEFINES_SVH

// register indices on the plain register port
`define ADDR_CONTROL      4'h0
`define ADDR_PERIOD       4'h1
`define ADDR_COUNT        4'h2
`define ADDR_IRQ_STATUS   4'h3
`define ADDR_IRQ_MASK     4'h4
`define ADDR_IRQ_CONFIG   4'h5

// control word field positions
`define CTRL_RUN_BIT      15
`define CTRL_IDLE_BIT     13
`define CTRL_GATE_BIT     6
`define CTRL_PS_HI        5
`define CTRL_PS_LO        4
`define CTRL_SYNC_BIT     2
`define CTRL_SRC_BIT      1
`define CTRL_IMPL_MASK    16'hA076

// interrupt status and mask bit positions
`define IRQ_MATCH_BIT     0
`define IRQ_GATE_BIT      1

// interrupt configuration field positions
`define IRQ_CFG_EN_BIT    0
`define IRQ_CFG_PRIO_HI   6
`define IRQ_CFG_PRIO_LO   4

// prescaler terminal counts, divide ratio minus one
`define PS_LAST_DIV1      8'h00
`define PS_LAST_DIV8      8'h07
`define PS_LAST_DIV64     8'h3F
`define PS_LAST_DIV256    8'hFF

// reset values
`define RST_CONTROL       16'h0000
`define RST_PERIOD        16'hFFFF
`define RST_COUNT         16'h0000
`define RST_IRQ_BITS      2'h0
`define RST_PRIO          3'h0

`endif

//--- inc/timer_pkg.sv
package timer_pkg;

    // one register port request, sampled on a rising edge
    typedef struct packed {
        logic [3:0]  addr;
        logic [15:0] wdata;
        logic        we;
        logic        re;
    } bus_req_t;

    // implemented control fields
    typedef struct packed {
        logic       count_run;
        logic       idle_halt;
        logic       gated_accumulate;
        logic [1:0] prescale_select;
        logic       ext_clock_sync;
        logic       clock_source_select;
    } timer_ctrl_t;

    // counting source as decoded from the control fields
    typedef enum logic [1:0] {
        MODE_TIMER,
        MODE_GATED,
        MODE_SYNC_COUNT,
        MODE_ASYNC_COUNT
    } count_mode_t;

endpackage

//--- logic/pin_sync.sv
`timescale 1ns/1ns
module pin_sync
(
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic ce_i,
    // raw pin and its clean views
    input  wire logic pin_i,
    output logic      level_o,
    output logic      rise_o,
    output logic      fall_o
);
    logic stage1;
    logic stage2;
    logic history;
    logic next_stage1;
    logic next_stage2;
    logic next_history;

    // two flops against metastability, a third keeps the last clean level
    always_comb
    begin
        next_stage1  = pin_i;
        next_stage2  = stage1;
        next_history = stage2;
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            stage1  <= 1'b0;
            stage2  <= 1'b0;
            history <= 1'b0;
        end
        else if (ce_i)
        begin
            stage1  <= next_stage1;
            stage2  <= next_stage2;
            history <= next_history;
        end
    end

    // edges look only at the settled stages
    assign level_o = stage2;
    assign rise_o  = stage2 & ~history;
    assign fall_o  = ~stage2 & history;
endmodule

//--- logic/prescaler.sv
`timescale 1ns/1ns
`include "timer_defines.svh"
module prescaler
(
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       ce_i,
    // control
    input  wire logic       clear_i,
    input  wire logic [1:0] select_i,
    // ticks in and out
    input  wire logic       tick_i,
    output logic            tick_o
);
    logic [7:0] count;
    logic [7:0] next_count;

    // terminal count for each ratio
    function automatic logic [7:0] last_count(input logic [1:0] sel);
        case (sel)
            2'h3:    last_count = `PS_LAST_DIV256;
            2'h2:    last_count = `PS_LAST_DIV64;
            2'h1:    last_count = `PS_LAST_DIV8;
            default: last_count = `PS_LAST_DIV1;
        endcase
    endfunction

    // one output tick per ratio input ticks; a clear restarts the phase
    always_comb
    begin
        next_count = count;
        if (clear_i)
            next_count = 8'h00;
        else if (tick_i)
            next_count = (count == last_count(select_i)) ? 8'h00 : 8'(count + 8'h01);
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            count <= 8'h00;
        else if (ce_i)
            count <= next_count;
    end

    assign tick_o = tick_i & ~clear_i & (count == last_count(select_i));
endmodule

//--- tb/sixteen_bit_gated_timer_tb_top.sv
`timescale 1ns/1ns
`include "timer_defines.svh"
`define CHECK(got, exp) chk(got, exp)
module sixteen_bit_gated_timer_tb_top
    import timer_pkg::*;
();
    // clock, reset, register port
    logic        clk_i;
    logic        rst_n_i;
    logic        ce_i;
    bus_req_t    bus;
    logic [15:0] rdata_o;
    // pin, power state, interrupt
    logic        pin;
    logic        idle;
    logic        sleep;
    logic        irq_o;
    logic [2:0]  irq_priority_o;
    // bench bookkeeping
    int          errors;
    int          checked;
    int          cycles;
    logic [15:0] v0;
    logic [15:0] v1;
    localparam logic [15:0] RST_VAL [0:5] = '{16'h0000, 16'hFFFF, 16'h0000,
                                               16'h0000, 16'h0000, 16'h0000};

    sixteen_bit_gated_timer dut
    (
        .clk_i           (clk_i),
        .rst_n_i         (rst_n_i),
        .ce_i            (ce_i),
        .bus_i           (bus),
        .rdata_o         (rdata_o),
        .ext_clock_pin_i (pin),
        .cpu_idle_i      (idle),
        .cpu_sleep_i     (sleep),
        .irq_o           (irq_o),
        .irq_priority_o  (irq_priority_o)
    );

    // free-running 250 MHz clock
    always #2 clk_i = ~clk_i;

    task automatic close_out();
        $display("counts: %0d compared, %0d mismatched", checked, errors);
        if (errors == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // hang guard, well above the few thousand cycles the tests need
    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            errors = errors + 1;
            close_out();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked = checked + 1;
        if (got !== exp)
        begin
            errors = errors + 1;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one-cycle write strobe, released at the sampling edge
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_i);
        bus <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
        @(posedge clk_i);
        bus <= '0;
    endtask

    // data stand only in the cycle after the strobe, so sample mid-cycle
    task automatic rd(input logic [3:0] a, output logic [15:0] v);
        @(posedge clk_i);
        bus <= '{addr: a, wdata: 16'h0000, we: 1'b0, re: 1'b1};
        @(posedge clk_i);
        bus <= '0;
        @(negedge clk_i);
        v = rdata_o;
    endtask

    // pin changes only right after a rising edge
    task automatic pin_pulse(input int hi, input int lo);
        @(posedge clk_i);
        pin <= 1'b1;
        repeat (hi) @(posedge clk_i);
        pin <= 1'b0;
        repeat (lo) @(posedge clk_i);
    endtask

    initial
    begin
        clk_i = 1'b0;
        rst_n_i = 1'b0;
        ce_i = 1'b1;
        bus = '0;
        pin = 1'b0;
        idle = 1'b0;
        sleep = 1'b0;
        errors = 0;
        checked = 0;
        cycles = 0;
        repeat (10) @(posedge clk_i);
        rst_n_i <= 1'b1;

        // reset values, unmapped read, unimplemented control bits
        for (int a = 0; a < 6; a++)
        begin
            rd(4'(a), v0);
            `CHECK(v0, RST_VAL[a]);
        end
        `CHECK(16'(irq_o), 16'h0000);
        rd(4'hF, v0);
        `CHECK(v0, 16'h0000);
        wr(`ADDR_CONTROL, 16'hFFFF);
        rd(`ADDR_CONTROL, v0);
        `CHECK(v0, 16'hA076);
        wr(`ADDR_CONTROL, 16'h0000);
        rd(`ADDR_COUNT, v0);
        repeat (20) @(posedge clk_i);
        rd(`ADDR_COUNT, v1);
        `CHECK(v1 - v0, 16'h0000);
        $display("test registers done");

        // every ratio over a 256-cycle window; ratio 1 also loses 50 frozen cycles
        for (int i = 0; i < 4; i++)
        begin
            wr(`ADDR_COUNT, 16'h0000);
            wr(`ADDR_CONTROL, 16'h8004 | 16'(i << 4));
            rd(`ADDR_COUNT, v0);
            repeat (100) @(posedge clk_i);
            ce_i <= (i != 0) ? 1'b1 : 1'b0;
            repeat (50) @(posedge clk_i);
            ce_i <= 1'b1;
            repeat (104) @(posedge clk_i);
            rd(`ADDR_COUNT, v1);
            `CHECK(v1 - v0, (i == 0) ? 16'd206 : 16'(256 >> (3 * i - (i == 3))));
        end
        $display("test prescale done");

        // idle with and without the halt bit
        @(posedge clk_i);
        idle <= 1'b1;
        for (int j = 0; j < 2; j++)
        begin
            wr(`ADDR_CONTROL, (j != 0) ? 16'hA000 : 16'h8000);
            rd(`ADDR_COUNT, v0);
            repeat (254) @(posedge clk_i);
            rd(`ADDR_COUNT, v1);
            `CHECK(v1 - v0, (j != 0) ? 16'd0 : 16'd256);
        end
        @(posedge clk_i);
        idle <= 1'b0;
        $display("test idle done");

        // period match wraps to zero and raises the interrupt
        wr(`ADDR_CONTROL, 16'h0000);
        wr(`ADDR_PERIOD, 16'h0003);
        wr(`ADDR_COUNT, 16'h0000);
        wr(`ADDR_IRQ_MASK, 16'h0001);
        wr(`ADDR_IRQ_CONFIG, 16'h0051);
        @(negedge clk_i);
        `CHECK(16'(irq_priority_o), 16'h0005);
        `CHECK(16'(irq_o), 16'h0000);
        wr(`ADDR_CONTROL, 16'h8000);
        for (int k = 0; k < 50 && irq_o !== 1'b1; k++)
            @(negedge clk_i);
        `CHECK(16'(irq_o), 16'h0001);
        wr(`ADDR_IRQ_CONFIG, 16'h0050);
        @(negedge clk_i);
        `CHECK(16'(irq_o), 16'h0000);
        wr(`ADDR_IRQ_CONFIG, 16'h0051);
        for (int k = 0; k < 3; k++)
        begin
            rd(`ADDR_COUNT, v0);
            rd(`ADDR_COUNT, v1);
            `CHECK(v1, (v0 + 16'd2) & 16'h0003);
        end
        wr(`ADDR_IRQ_MASK, 16'h0000);
        @(negedge clk_i);
        `CHECK(16'(irq_o), 16'h0000);
        wr(`ADDR_IRQ_MASK, 16'h0003);
        wr(`ADDR_CONTROL, 16'h0000);
        wr(`ADDR_IRQ_STATUS, 16'h0003);
        rd(`ADDR_IRQ_STATUS, v0);
        `CHECK(v0, 16'h0000);
        `CHECK(16'(irq_o), 16'h0000);
        $display("test match done");

        // gated accumulation: counts only while the pin is high, event on its fall
        wr(`ADDR_PERIOD, 16'hFFFF);
        wr(`ADDR_COUNT, 16'h0000);
        wr(`ADDR_CONTROL, 16'h8040);
        repeat (10) @(posedge clk_i);
        rd(`ADDR_COUNT, v0);
        `CHECK(v0, 16'h0000);
        pin_pulse(20, 10);
        rd(`ADDR_COUNT, v1);
        `CHECK(v1, 16'd20);
        rd(`ADDR_IRQ_STATUS, v0);
        `CHECK(v0, 16'h0002);
        `CHECK(16'(irq_o), 16'h0001);
        wr(`ADDR_IRQ_STATUS, 16'h0003);
        $display("test gate done");

        // pin edges: unsynced in sleep, synced awake, synced in sleep
        for (int m = 0; m < 3; m++)
        begin
            wr(`ADDR_CONTROL, 16'h0000);
            wr(`ADDR_COUNT, 16'h0000);
            wr(`ADDR_CONTROL, (m != 0) ? 16'h8046 : 16'h8042);
            sleep <= (m != 1) ? 1'b1 : 1'b0;
            repeat (5) pin_pulse(4, 4);
            repeat (6) @(posedge clk_i);
            rd(`ADDR_COUNT, v1);
            `CHECK(v1, (m == 2) ? 16'd0 : 16'd5);
            @(posedge clk_i);
            sleep <= 1'b0;
        end
        $display("test pin counting done");
        close_out();
    end
endmodule
